//--- include/pull_in_cfg_pkg.sv
// Package: register map, field layouts and reset values of the loop pull-in configuration block
package pull_in_cfg_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] ADDR_MINI_HOLD  = 8'h40;
  localparam logic [7:0] ADDR_LIMIT_LOW  = 8'h41;
  localparam logic [7:0] ADDR_LIMIT_HIGH = 8'h42;
  localparam logic [7:0] ADDR_HOLD_CTRL  = 8'h50;
  localparam logic [7:0] ADDR_STATUS     = 8'h51;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_MINI_HOLD  = 8'h00;
  localparam logic [7:0] RST_LIMIT_LOW  = 8'h76;
  localparam logic [7:0] RST_LIMIT_HIGH = 8'h00;
  localparam logic [7:0] RST_HOLD_CTRL  = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int MINI_SEL_LSB   = 3;
  localparam int HOLD_HI_LSB    = 0;
  localparam int LIMIT_HI_BITS  = 2;
  localparam int AUTO_AVG_BIT   = 7;
  localparam int FAST_AVG_BIT   = 6;
  localparam int MAN_HOLD_BIT   = 4;
  localparam int CAL_EN_BIT     = 0;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    MINI_FOLLOW = 2'b00,
    MINI_FREEZE = 2'b01,
    MINI_FAST   = 2'b10,
    MINI_SLOW   = 2'b11
  } mini_sel_t;

  typedef enum logic [1:0] {
    SRC_FREEZE = 2'b00,
    SRC_FAST   = 2'b01,
    SRC_SLOW   = 2'b10,
    SRC_MANUAL = 2'b11
  } hold_src_t;

  typedef enum logic [1:0] {
    ST_FREE   = 2'b00,
    ST_LOCKED = 2'b01,
    ST_MINI   = 2'b10,
    ST_HOLD   = 2'b11
  } loop_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] offset;
  } freq_sample_t;

endpackage

//--- src/offset_clamp.sv
// Symmetric clamp of a signed loop frequency offset against a scaled unsigned limit
`timescale 1ns/1ps
`default_nettype none

module offset_clamp
  import pull_in_cfg_pkg::*;
#(
  parameter int OFS_W   = 32,
  parameter int LIMIT_W = 10,
  parameter int STEP    = 1
) (
  // Clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  // Offset in, limit and calibration reference
  input  wire freq_sample_t             raw,
  input  wire logic [LIMIT_W-1:0]       limit,
  input  wire logic signed [OFS_W-1:0]  cal_ref,
  input  wire logic                     cal_en,
  // Clamped offset out
  output freq_sample_t                  clamped,
  output logic                          clipping
);

  logic signed [OFS_W-1:0] rel;
  logic signed [OFS_W-1:0] bound;
  logic signed [OFS_W-1:0] res;
  logic                    clip_d;
  freq_sample_t            out_d;
  freq_sample_t            out_q;
  logic                    clip_q;

  always_comb begin
    // Offset is judged against the calibrated oscillator when calibration is on
    rel   = cal_en ? $signed(raw.offset) - cal_ref : $signed(raw.offset);
    bound = $signed(OFS_W'(limit) * OFS_W'(STEP));
    res    = rel;
    clip_d = 1'b0;
    if (rel > bound) begin
      res    = bound;
      clip_d = 1'b1;
    end else if (rel < -bound) begin
      res    = -bound;
      clip_d = 1'b1;
    end
    out_d.valid  = raw.valid;
    out_d.offset = cal_en ? 32'(res + cal_ref) : 32'(res);
    if (!raw.valid) begin
      clip_d = clip_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      out_q  <= '0;
      clip_q <= 1'b0;
    end else begin
      out_q  <= out_d;
      clip_q <= clip_d;
    end
  end

  assign clamped  = out_q;
  assign clipping = clip_q;

endmodule

`default_nettype wire

//--- src/pull_in_limit_cfg.sv
// Loop pull-in limit and mini-holdover configuration with holdover frequency selection
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module pull_in_limit_cfg
  import pull_in_cfg_pkg::*;
#(
  parameter int OFS_W   = 32,
  parameter int LIMIT_W = 10,
  parameter int STEP    = 1
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // Register port
  input  wire reg_req_t          req,
  output logic [7:0]             rdata,
  // Loop status inputs
  input  wire logic              ref_ok,
  input  wire logic              loop_locked,
  input  wire logic              ref_failed,
  input  wire logic signed [OFS_W-1:0] cal_ref,
  // Offsets of both main loops, averager values and manual frequency
  input  wire freq_sample_t      primary_loop_ofs,
  input  wire freq_sample_t      secondary_loop_ofs,
  input  wire logic [OFS_W-1:0]  fast_avg,
  input  wire logic [OFS_W-1:0]  slow_avg,
  input  wire logic [OFS_W-1:0]  manual_freq,
  // Results
  output freq_sample_t           primary_loop_lim,
  output freq_sample_t           secondary_loop_lim,
  output logic [OFS_W-1:0]       hold_freq,
  output logic                   holding,
  output logic [1:0]             loop_state
);

  // ==========================================================================
  // Registers
  logic [7:0]   mini_q,  mini_d;
  logic [7:0]   lim_lo_q, lim_lo_d;
  logic [1:0]   lim_hi_q, lim_hi_d;
  logic [7:0]   ctrl_q,  ctrl_d;
  logic [7:0]   rdata_q, rdata_d;
  loop_state_t  st_q,    st_d;
  logic [OFS_W-1:0] last_q, last_d;
  logic [OFS_W-1:0] hold_q, hold_d;
  logic         clip_p, clip_s;
  logic [LIMIT_W-1:0] pull_in_limit_value;
  hold_src_t    src;

  function automatic hold_src_t full_src(input logic [7:0] c);
    if (c[MAN_HOLD_BIT])
      return SRC_MANUAL;
    else if (!c[AUTO_AVG_BIT])
      return SRC_FREEZE;
    else
      return c[FAST_AVG_BIT] ? SRC_FAST : SRC_SLOW;
  endfunction

  assign pull_in_limit_value = {lim_hi_q, lim_lo_q};

  always_comb begin
    mini_d   = mini_q;
    lim_lo_d = lim_lo_q;
    lim_hi_d = lim_hi_q;
    ctrl_d   = ctrl_q;
    rdata_d  = 8'h00;
    if (req.wr) begin
      unique case (req.addr)
        ADDR_MINI_HOLD:  mini_d   = req.wdata;
        ADDR_LIMIT_LOW:  lim_lo_d = req.wdata;
        ADDR_LIMIT_HIGH: lim_hi_d = req.wdata[LIMIT_HI_BITS-1:0];
        ADDR_HOLD_CTRL:  ctrl_d   = req.wdata;
        default: ;
      endcase
    end
    if (req.rd) begin
      unique case (req.addr)
        ADDR_MINI_HOLD:  rdata_d = mini_q;
        ADDR_LIMIT_LOW:  rdata_d = lim_lo_q;
        ADDR_LIMIT_HIGH: rdata_d = {6'h00, lim_hi_q};
        ADDR_HOLD_CTRL:  rdata_d = ctrl_q;
        ADDR_STATUS:     rdata_d = {4'h0, clip_s, clip_p, st_q};
        default:         rdata_d = 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // Loop state: mini-holdover on a brief loss while locked
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_FREE:   if (loop_locked && ref_ok) st_d = ST_LOCKED;
      ST_LOCKED: if (!ref_ok) st_d = ST_MINI;
      ST_MINI: begin
        if (ref_failed) st_d = ST_HOLD;
        else if (ref_ok) st_d = ST_LOCKED;
      end
      ST_HOLD:   if (ref_ok && loop_locked) st_d = ST_LOCKED;
    endcase
  end

  // ==========================================================================
  // Held frequency source
  always_comb begin
    unique case (mini_sel_t'(mini_q[MINI_SEL_LSB +: 2]))
      MINI_FREEZE: src = SRC_FREEZE;
      MINI_FAST:   src = SRC_FAST;
      MINI_SLOW:   src = SRC_SLOW;
      MINI_FOLLOW: src = full_src(ctrl_q);
    endcase
    if (st_q == ST_HOLD) src = full_src(ctrl_q);
    last_d = (st_q == ST_LOCKED) ? primary_loop_lim.offset : last_q;
    hold_d = hold_q;
    if (st_q == ST_MINI || st_q == ST_HOLD) begin
      unique case (src)
        SRC_FREEZE: hold_d = last_q;
        SRC_FAST:   hold_d = fast_avg;
        SRC_SLOW:   hold_d = slow_avg;
        SRC_MANUAL: hold_d = manual_freq;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mini_q   <= RST_MINI_HOLD;
      lim_lo_q <= RST_LIMIT_LOW;
      lim_hi_q <= RST_LIMIT_HIGH[1:0];
      ctrl_q   <= RST_HOLD_CTRL;
      rdata_q  <= 8'h00;
      st_q     <= ST_FREE;
      last_q   <= '0;
      hold_q   <= '0;
    end else begin
      mini_q   <= mini_d;
      lim_lo_q <= lim_lo_d;
      lim_hi_q <= lim_hi_d;
      ctrl_q   <= ctrl_d;
      rdata_q  <= rdata_d;
      st_q     <= st_d;
      last_q   <= last_d;
      hold_q   <= hold_d;
    end
  end

  // ==========================================================================
  // One limit bounds both loops alike
  offset_clamp #(.OFS_W(OFS_W), .LIMIT_W(LIMIT_W), .STEP(STEP)) u_clamp_p (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .raw      (primary_loop_ofs),
    .limit    (pull_in_limit_value),
    .cal_ref  (cal_ref),
    .cal_en   (ctrl_q[CAL_EN_BIT]),
    .clamped  (primary_loop_lim),
    .clipping (clip_p)
  );

  offset_clamp #(.OFS_W(OFS_W), .LIMIT_W(LIMIT_W), .STEP(STEP)) u_clamp_s (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .raw      (secondary_loop_ofs),
    .limit    (pull_in_limit_value),
    .cal_ref  (cal_ref),
    .cal_en   (ctrl_q[CAL_EN_BIT]),
    .clamped  (secondary_loop_lim),
    .clipping (clip_s)
  );

  assign rdata      = rdata_q;
  assign hold_freq  = hold_q;
  assign holding    = st_q[1];
  assign loop_state = st_q;

endmodule

`default_nettype wire

//--- verification/pull_in_limit_cfg_sva.sv
// Checker: port properties of the pull-in limit block
`timescale 1ns/1ps
`default_nettype none
module pull_in_limit_cfg_sva
  import pull_in_cfg_pkg::*;
#(parameter int OFS_W = 32) (
  // Clock and reset
  input wire logic             clk_sys,
  input wire logic             rst_n,
  // Register port
  input wire reg_req_t         req,
  input wire logic [7:0]       rdata,
  // Loop side
  input wire logic             ref_ok,
  input wire logic             ref_failed,
  input wire freq_sample_t     primary_loop_ofs,
  input wire freq_sample_t     primary_loop_lim,
  input wire logic [OFS_W-1:0] hold_freq,
  input wire logic             holding,
  input wire logic [1:0]       loop_state
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ======
  // Register port
  rdata_idle_a: assert property (!$past(req.rd) |-> rdata == 8'h00) else $error("read data outside answer");
  high_unused_a: assert property (req.rd && req.addr == ADDR_LIMIT_HIGH |=> rdata[7:2] == 6'h00)
    else $error("unused limit bits not zero");
  status_state_a: assert property (req.rd && req.addr == ADDR_STATUS |=> rdata[1:0] == $past(loop_state))
    else $error("status does not show state");
  // ======
  // Loop state, holding and clamped sample valid
  mini_entry_a: assert property (loop_state == ST_LOCKED && !ref_ok |=> loop_state == ST_MINI)
    else $error("no mini-holdover on reference loss");
  hold_entry_a: assert property (loop_state == ST_MINI && !ref_ok && ref_failed |=> loop_state == ST_HOLD)
    else $error("no holdover on failed reference");
  holding_flag_a: assert property (holding == (loop_state inside {ST_MINI, ST_HOLD})) else $error("holding flag wrong");
  hold_still_a: assert property (loop_state == ST_LOCKED && $past(loop_state) == ST_LOCKED |-> $stable(hold_freq))
    else $error("held value moved while locked");
  lim_valid_a: assert property (primary_loop_ofs.valid |=> primary_loop_lim.valid)
    else $error("clamped sample missing");
endmodule
bind pull_in_limit_cfg pull_in_limit_cfg_sva #(.OFS_W(OFS_W)) i_sva (.clk_sys(clk_sys), .rst_n(rst_n), .req(req),
  .rdata(rdata), .ref_ok(ref_ok), .ref_failed(ref_failed), .primary_loop_ofs(primary_loop_ofs),
  .primary_loop_lim(primary_loop_lim), .hold_freq(hold_freq), .holding(holding), .loop_state(loop_state));
`default_nettype wire

//--- verification/pull_in_limit_cfg_test.sv
// Testbench: registers, offset clamp and held frequency choice
`timescale 1ns/1ps
`default_nettype none
module pull_in_limit_cfg_test
  import pull_in_cfg_pkg::*;
;
  // Larger step shows the scaling of the limit
  localparam int STEP = 2;
  logic               clk_sys, rst_n, ref_ok, loop_locked, ref_failed, holding;
  reg_req_t           req;
  logic [7:0]         d;
  logic [7:0]         rdata;
  logic signed [31:0] cal_ref;
  freq_sample_t       po, so, pl, sl;
  logic [31:0]        fast_avg, slow_avg, manual_freq, hold_freq;
  logic [31:0]        exp_h[4];
  logic [1:0]         loop_state;
  int                 fail_count, check_count, cyc, lim, c, cr, op, os, m;
  pull_in_limit_cfg #(.OFS_W(32), .LIMIT_W(10), .STEP(STEP)) i_pull_in_limit_cfg (.clk_sys(clk_sys), .rst_n(rst_n),
    .req(req), .rdata(rdata), .ref_ok(ref_ok), .loop_locked(loop_locked), .ref_failed(ref_failed),
    .cal_ref(cal_ref), .primary_loop_ofs(po), .secondary_loop_ofs(so), .fast_avg(fast_avg), .slow_avg(slow_avg),
    .manual_freq(manual_freq), .primary_loop_lim(pl), .secondary_loop_lim(sl), .hold_freq(hold_freq),
    .holding(holding), .loop_state(loop_state));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Generous ceiling: the sequence needs well under 2000 cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end
  task close_out;
    if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys) req <= '{a, v, 1'b1, 1'b0};
    @(posedge clk_sys) req.wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys) req.rd <= 1'b0;
    #1 v = rdata;
  endtask
  function automatic int clampm(int o, int r, int l);
    int x;
    x = o - r;
    if (x > l * STEP) x = l * STEP;
    if (x < -l * STEP) x = -l * STEP;
    return x + r;
  endfunction
  task settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  initial begin
    {rst_n, ref_ok, loop_locked, ref_failed} = 4'h0;
    req = '0;
    cal_ref = '0;
    po = '0;
    so = '0;
    void'($urandom(32'hD192));
    fast_avg = $urandom;
    slow_avg = $urandom;
    manual_freq = $urandom;
    exp_h = '{slow_avg, 32'h1, fast_avg, slow_avg};
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(ADDR_LIMIT_LOW, d); chk(d, 8'h76);
    rd(ADDR_LIMIT_HIGH, d); chk(d, 8'h00);
    rd(8'h7F, d); chk(d, 8'h00);
    for (c = 0; c < 2; c++) begin
      lim = $urandom_range(1023, 1);
      cr = c ? int'($urandom_range(400, 0)) - 200 : 0;
      wr(ADDR_LIMIT_LOW, lim[7:0]);
      wr(ADDR_LIMIT_HIGH, {6'h3F, lim[9:8]});
      wr(ADDR_HOLD_CTRL, c[7:0]);
      rd(ADDR_LIMIT_HIGH, d); chk(d, {6'h00, lim[9:8]});
      rd(ADDR_LIMIT_LOW, d); chk(d, lim[7:0]);
      @(posedge clk_sys) cal_ref <= cr;
      repeat (40) begin
        op = int'($urandom_range(4 * lim * STEP, 0)) - 2 * lim * STEP + cr;
        os = int'($urandom_range(4 * lim * STEP, 0)) - 2 * lim * STEP + cr;
        @(posedge clk_sys) po <= '{1'b1, op};
        so <= '{1'b1, os};
        settle(1);
        chk(pl.offset, clampm(op, cr, lim));
        chk(sl.offset, clampm(os, cr, lim));
      end
      // Last samples stay valid, so both clip flags still reflect them
      rd(ADDR_STATUS, d);
      chk(d[3:2], {clampm(os, cr, lim) != os, clampm(op, cr, lim) != op});
    end
    // Small offset so the frozen value never clips
    wr(ADDR_HOLD_CTRL, 8'h80);
    cal_ref <= '0;
    po <= '{1'b1, 32'h1};
    ref_ok <= 1'b1;
    loop_locked <= 1'b1;
    settle(4);
    for (c = 0; c < 4; c++) begin
      m = (c + 1) % 4;
      wr(ADDR_MINI_HOLD, {3'h0, m[1:0], 3'h0});
      @(posedge clk_sys) ref_ok <= 1'b0;
      settle(3);
      chk(loop_state, ST_MINI);
      chk(holding, 1'b1);
      chk(hold_freq, exp_h[m]);
      @(posedge clk_sys) ref_ok <= 1'b1;
      settle(3);
      chk(loop_state, ST_LOCKED);
      chk(holding, 1'b0);
    end
    wr(ADDR_HOLD_CTRL, 8'hC0);
    @(posedge clk_sys) ref_ok <= 1'b0;
    settle(2);
    @(posedge clk_sys) ref_failed <= 1'b1;
    settle(3);
    chk(loop_state, ST_HOLD);
    chk(hold_freq, fast_avg);
    wr(ADDR_HOLD_CTRL, 8'hD0);
    settle(2);
    chk(hold_freq, manual_freq);
    rd(ADDR_STATUS, d); chk(d[1:0], ST_HOLD);
    close_out();
  end
endmodule
`default_nettype wire
